// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync
    import port_b_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins in, clean levels out
    pin_sync_if.sync_side pins
);
    logic [3:0] stage1_reg; // Metastable catch, read only by stage two
    logic [3:0] stage2_reg; // Second stage
    logic [3:0] stage3_reg; // Third stage
    logic [3:0] clean_reg;  // Accepted level

    // Shift chain
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= 4'h0;
            stage2_reg <= 4'h0;
            stage3_reg <= 4'h0;
        end else begin
            stage1_reg <= pins.raw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Accept each bit only when the two later stages agree
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clean_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    clean_reg[i] <= stage3_reg[i];
                end
            end
        end
    end

    assign pins.clean = clean_reg;
endmodule : pin_sync

// *** rtl/pin_sync_if.sv ***
// Interface carrying raw pin levels into the synchroniser and clean levels out
`timescale 1ns/100ps
interface pin_sync_if;
    logic [3:0] raw;    // Asynchronous pin levels
    logic [3:0] clean;  // Debounced, synchronised levels
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface : pin_sync_if

// *** rtl/port_b_pkg.sv ***
// Package with register map, field positions and reset values of the upper port half
package port_b_pkg;
    // Register indices on the plain register port (3-bit address)
    localparam logic [2:0] ADDR_PIN_LEVEL = 3'h0;
    localparam logic [2:0] ADDR_OUT_LATCH = 3'h1;
    localparam logic [2:0] ADDR_DIRECTION = 3'h2;
    localparam logic [2:0] ADDR_INT_MAIN = 3'h3;
    localparam logic [2:0] ADDR_INT_EDGE = 3'h4;
    localparam logic [2:0] ADDR_INT_EXT = 3'h5;
    localparam logic [2:0] ADDR_ANALOG_CFG = 3'h6;
    // Field positions
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int CHANGE_IE_BIT = 3;
    localparam int PULLUP_DIS_BIT = 7;
    localparam int CHANGE_PRIO_BIT = 0;
    localparam int PCFG_LSB = 0;
    localparam int VCFG_LSB = 4;
    // Implemented-bit masks; other bits read as zero
    localparam logic [7:0] INT_EDGE_MASK = 8'hf5;
    localparam logic [7:0] INT_EXT_MASK = 8'hdb;
    localparam logic [7:0] ANALOG_CFG_MASK = 8'h3f;
    // Reset values
    localparam logic [7:0] OUT_LATCH_RST = 8'h00;
    localparam logic [7:0] DIRECTION_RST = 8'hff;
    localparam logic [7:0] INT_MAIN_RST = 8'h00;
    localparam logic [7:0] INT_EDGE_RST = 8'h80;
    localparam logic [7:0] INT_EXT_RST = 8'h00;
    localparam logic [7:0] ANALOG_CFG_RST = 8'h00;
    // Port configuration loaded after reset release
    localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
    localparam logic [3:0] PCFG_PORT_DIGITAL = 4'h7;
    // Highest configuration code for which bit 4 is an analog channel
    localparam logic [3:0] PCFG_BIT4_ANALOG_MAX = 4'h3;
    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;
endpackage : port_b_pkg

// *** rtl/port_b_upper_pins.sv ***
// Upper half of the bidirectional port: pins 7..4, change detect and overrides
`timescale 1ns/100ps
//
// Contract
// - Cleared direction drives latch; analog ignored.
// - Set direction reads pin, pull-up, analog disables.
// - Pins 7..4 as inputs detect change.
// - Low-voltage config makes bit5 programming entry.
// - Serial mode: bit6 clock, bit7 data.
// - Serial mode disables other clock/data functions.
// - Reset analog default follows analog config.
// - Channel-2 routed here when select zero.
// - Overriding functions ignore direction bits.
// - Latch register reads latched values.
// - Unimplemented bits read zero.
// - Analog config fields at 3:0, 5:4.
// - Set direction tristates, clear drives latch.
// - Inputs compared with last-access snapshot, ORed.
// - Mismatch keeps flag set until port access.
// - Pull-up off for outputs and reset.
module port_b_upper_pins
    import port_b_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,

    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,

    // Pins 7..4 (index 0 is pin 4)
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [3:0] pullup_en,

    // Configuration levels
    input wire logic lowvolt_prog_enable_cfg,
    input wire logic analog_at_reset_cfg,
    input wire logic capcomp2_pin_select_cfg,

    // Serial programming and debug
    input wire logic serial_prog_active,
    input wire logic serial_data_drive,
    input wire logic serial_data_oe,
    output logic serial_prog_clock,
    output logic serial_prog_data,
    output logic lowvolt_prog_entry,

    // Status toward the rest of the chip
    output logic port_change_flag,
    output logic port_change_irq_enable,
    output logic port_change_irq_priority,
    output logic pin4_analog,
    output logic capcomp_channel_2_here
);
    // Software-visible storage
    // Bits that do not exist are masked on write
    logic [7:0] output_latch_reg;       // Output data latch
    logic [7:0] direction_control_reg;  // 1 = input, 0 = output
    logic [7:0] int_main_reg;           // Main interrupt control (flag bit kept apart)
    logic [7:0] int_edge_reg;           // Edge/priority control, holds pull-up disable
    logic [7:0] int_ext_reg;            // External interrupt control
    logic [7:0] analog_cfg_reg;         // Port and reference configuration
    logic change_flag_reg;              // Sticky port-change flag
    logic [3:0] snapshot_reg;           // Pin levels caught at the last port access
    logic init_done_reg;                // Analog default loaded after reset release

    // Registered outputs
    // One flop per top-level output
    logic [7:0] rd_data_reg;
    logic [3:0] pin_out_reg;
    logic [3:0] pin_oe_reg;
    logic [3:0] pullup_en_reg;
    logic serial_clock_reg;
    logic serial_data_reg;
    logic lv_entry_reg;
    logic pin4_analog_reg;
    logic capcomp_here_reg;

    // Combinational helpers
    // Pure decodes; none reaches a port unflopped
    logic [3:0] pin_sync;     // Clean synchronised pin levels
    logic [3:0] digital_ok;   // Pin still in general-purpose digital use
    logic [3:0] watch;        // Pins taking part in change comparison
    logic [3:0] port_view;    // Upper nibble as read through the port register
    logic mismatch;           // Any watched pin differs from snapshot
    logic port_access;        // Read or write of the port register
    logic is_analog4;         // Bit 4 configured as analog channel
    logic [7:0] rd_data_next;

    // Synchroniser for the four pins
    // Pins move at any time; only the clean levels
    // feed the port read, the change comparison and
    // the programming inputs, never the raw pins
    pin_sync_if sync_bus ();
    assign sync_bus.raw = pin_in;
    pin_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pins(sync_bus.sync_side)
    );
    // Clean levels back from the synchroniser
    assign pin_sync = sync_bus.clean;

    // Pin function selection
    // A pin leaves plain use when an override owns it:
    // bit 4 as analog channel, bit 5 under the
    // low-voltage strap, bits 6 and 7 in serial mode.
    // One mask gates port view, change compare and
    // pull-ups, so the three always agree.
    always_comb begin
        is_analog4 = (analog_cfg_reg[PCFG_LSB +: 4] <= PCFG_BIT4_ANALOG_MAX);
        // Start from full digital use, strip overrides
        digital_ok = 4'hf;
        if (is_analog4) begin
            digital_ok[0] = 1'b0;
        end
        if (lowvolt_prog_enable_cfg) begin
            digital_ok[1] = 1'b0;
        end
        // Both serial pins are taken together
        if (serial_prog_active) begin
            digital_ok[2] = 1'b0;
            digital_ok[3] = 1'b0;
        end
    end

    // Only digital inputs join the comparison; outputs are excluded
    // Without this a latch write to an output pin
    // would look like a pin change
    assign watch = digital_ok & direction_control_reg[7:4];
    assign mismatch = |(watch & (pin_sync ^ snapshot_reg));
    assign port_access = (rd_en || wr_en) && (addr == ADDR_PIN_LEVEL);
    // Overridden or analog pins read back as zero
    assign port_view = pin_sync & digital_ok;

    // Output latch and direction registers
    // The latch holds what software wrote, not the
    // pin level, so read-modify-write on it cannot
    // pick up a pin that the board holds low.
    // Direction resets to inputs: nothing is driven
    // until software asks for it.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            output_latch_reg <= OUT_LATCH_RST;
            direction_control_reg <= DIRECTION_RST;
        end else if (wr_en) begin
            // A port write lands in the latch as well
            if (addr == ADDR_PIN_LEVEL || addr == ADDR_OUT_LATCH) begin
                output_latch_reg <= wr_data;
            end
            if (addr == ADDR_DIRECTION) begin
                direction_control_reg <= wr_data;
            end
        end
    end

    // Interrupt control registers, flag excluded
    // The flag has its own process since hardware
    // sets it; set and clear meet in one place.
    // Writes to missing bits are dropped here.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            int_main_reg <= INT_MAIN_RST;
            int_edge_reg <= INT_EDGE_RST;
            int_ext_reg <= INT_EXT_RST;
        end else if (wr_en) begin
            case (addr)
                ADDR_INT_MAIN: int_main_reg <= wr_data;
                ADDR_INT_EDGE: int_edge_reg <= wr_data & INT_EDGE_MASK;
                ADDR_INT_EXT: int_ext_reg <= wr_data & INT_EXT_MASK;
                default: ;
            endcase
        end
    end

    // Analog configuration; the reset default is loaded one cycle after release
    // because a strap level may not be taken under the asynchronous reset
    // Limitation: a write in that first cycle is
    // lost, so software waits one cycle after reset.
    // The strap is read once, not tracked.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            analog_cfg_reg <= ANALOG_CFG_RST;
            init_done_reg <= 1'b0;
        end else if (!init_done_reg) begin
            init_done_reg <= 1'b1;
            analog_cfg_reg <= analog_at_reset_cfg ? {4'h0, PCFG_ALL_ANALOG}
                                                  : {4'h0, PCFG_PORT_DIGITAL};
        end else if (wr_en && addr == ADDR_ANALOG_CFG) begin
            analog_cfg_reg <= wr_data & ANALOG_CFG_MASK;
        end
    end

    // Snapshot of pin levels, renewed by any port access
    // A fresh snapshot is what ends a mismatch; after
    // it the flag stops being set and may be cleared.
    // Pins outside the comparison are caught too and
    // masked when compared.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            snapshot_reg <= 4'h0;
        end else if (port_access) begin
            snapshot_reg <= pin_sync;
        end
    end

    // Sticky change flag: a standing mismatch beats a software clear
    // Trade-off: a clear is ignored while a mismatch
    // stands, so software reads or writes the port
    // first; a change in the clear cycle is not lost.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            change_flag_reg <= 1'b0;
        end else if (mismatch) begin
            change_flag_reg <= 1'b1;
        end else if (wr_en && addr == ADDR_INT_MAIN) begin
            change_flag_reg <= wr_data[CHANGE_FLAG_BIT];
        end
    end

    // Read mux; data appears the cycle after the read strobe
    // Unmapped places and missing bits read zero;
    // the low nibble of the port is the lower half's.
    always_comb begin
        rd_data_next = 8'h00;
        case (addr)
            ADDR_PIN_LEVEL: rd_data_next = {port_view, 4'h0};
            ADDR_OUT_LATCH: rd_data_next = output_latch_reg;
            ADDR_DIRECTION: rd_data_next = direction_control_reg;
            // Flag kept apart, merged into bit 0
            ADDR_INT_MAIN: begin
                rd_data_next = int_main_reg;
                rd_data_next[CHANGE_FLAG_BIT] = change_flag_reg;
            end
            ADDR_INT_EDGE: rd_data_next = int_edge_reg;
            ADDR_INT_EXT: rd_data_next = int_ext_reg;
            ADDR_ANALOG_CFG: rd_data_next = analog_cfg_reg;
            default: rd_data_next = 8'h00;
        endcase
    end

    // Read data stands one cycle, zero otherwise,
    // so a stale byte is never taken for a reply
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg <= 8'h00;
        end else if (rd_en) begin
            rd_data_reg <= rd_data_next;
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    // Pin drivers: latch onto outputs, tristate on inputs, overrides win
    // Every pad signal leaves a flop, so the pads see
    // no glitch from the override decode. Overrides
    // win by coming later in the same process.
    // Outputs reset low with drivers off.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_out_reg <= 4'h0;
            pin_oe_reg <= 4'h0;
        end else begin
            pin_out_reg <= output_latch_reg[7:4];
            pin_oe_reg <= ~direction_control_reg[7:4];
            // Entry pin is input only, whatever direction
            if (lowvolt_prog_enable_cfg) begin
                pin_oe_reg[1] <= 1'b0;
            end
            // Clock pin listens; data pin obeys debug logic
            if (serial_prog_active) begin
                pin_oe_reg[2] <= 1'b0;
                pin_out_reg[3] <= serial_data_drive;
                pin_oe_reg[3] <= serial_data_oe;
            end
        end
    end

    // Weak pull-ups on digital inputs while the global disable is clear
    // A pull-up on a driven pin only wastes current.
    // The disable bit resets set, so pull-ups stay
    // off until software clears it.
    // Overridden pins get no pull-up either.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pullup_en_reg <= 4'h0;
        end else begin
            pullup_en_reg <= {4{~int_edge_reg[PULLUP_DIS_BIT]}}
                             & direction_control_reg[7:4] & digital_ok;
        end
    end

    // Programming and debug inputs taken from the clean pin levels
    // Limitation: about five cycles behind the pins,
    // so the programming clock must be far slower
    // than the core clock.
    // Each is zero outside its own mode.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            serial_clock_reg <= 1'b0;
            serial_data_reg <= 1'b0;
            lv_entry_reg <= 1'b0;
        end else begin
            serial_clock_reg <= serial_prog_active & pin_sync[2];
            serial_data_reg <= serial_prog_active & pin_sync[3];
            lv_entry_reg <= lowvolt_prog_enable_cfg & pin_sync[1];
        end
    end

    // Status and routing outputs
    // The routing select is a static strap; it is
    // flopped only so the output leaves a flop.
    // Channel 2 itself lives outside this block.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin4_analog_reg <= 1'b0;
            capcomp_here_reg <= 1'b0;
        end else begin
            pin4_analog_reg <= is_analog4;
            capcomp_here_reg <= ~capcomp2_pin_select_cfg;
        end
    end

    // Ports are plain copies of the flops above
    // and carry no logic of their own
    assign rd_data = rd_data_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign pullup_en = pullup_en_reg;
    assign serial_prog_clock = serial_clock_reg;
    assign serial_prog_data = serial_data_reg;
    assign lowvolt_prog_entry = lv_entry_reg;
    assign port_change_flag = change_flag_reg;
    assign port_change_irq_enable = int_main_reg[CHANGE_IE_BIT];
    assign port_change_irq_priority = int_edge_reg[CHANGE_PRIO_BIT];
    assign pin4_analog = pin4_analog_reg;
    assign capcomp_channel_2_here = capcomp_here_reg;
endmodule : port_b_upper_pins

// *** sim/pin_board.sv ***
// Board model: resolves the level at each upper pin
`timescale 1ns/100ps
module pin_board (
    // Clock
    input wire logic clk_sys,
    // Device side of the pins
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pullup_en,
    // Board drivers
    input wire logic [3:0] ext_level,
    input wire logic [3:0] ext_drive,
    // Resolved pin levels
    output logic [3:0] pin_in
);
    logic [3:0] float_reg = 4'h5; // A floating pin never holds a value
    // Wander every cycle so a missing pull-up shows up
    always_ff @(posedge clk_sys) begin
        float_reg <= ~float_reg;
    end
    // Device driver first, then board, then weak pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_drive[i]) pin_in[i] = ext_level[i];
            else if (pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_reg[i];
        end
    end
endmodule : pin_board

// *** sim/port_b_checker.sv ***
// Concurrent checks on the ports of the upper port half
`timescale 1ns/100ps
module port_b_checker
    import port_b_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    // Pins
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pullup_en,
    // Modes and status
    input wire logic lowvolt_prog_enable_cfg,
    input wire logic capcomp2_pin_select_cfg,
    input wire logic serial_prog_active,
    input wire logic serial_data_oe,
    input wire logic serial_prog_clock,
    input wire logic serial_prog_data,
    input wire logic lowvolt_prog_entry,
    input wire logic port_change_flag,
    input wire logic capcomp_channel_2_here
);
    // One clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Latch write then latch read returns the written byte
    sequence latch_wr_rd;
        wr_en && addr == ADDR_OUT_LATCH ##1 rd_en && addr == ADDR_OUT_LATCH;
    endsequence
    a_unmapped_zero: assert property ($past(rd_en) && $past(addr) == 3'h7 |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_analog_top_zero: assert property ($past(rd_en) && $past(addr) == ADDR_ANALOG_CFG |-> rd_data[7:6] == 2'h0)
        else $error("analog config top bits not zero");
    a_port_low_zero: assert property ($past(rd_en) && $past(addr) == ADDR_PIN_LEVEL |-> rd_data[3:0] == 4'h0)
        else $error("port low nibble not zero");
    a_latch_readback: assert property (latch_wr_rd |=> rd_data == $past(wr_data, 2))
        else $error("latch readback differs");
    a_serial_idle_low: assert property (!$past(serial_prog_active) |-> !serial_prog_clock && !serial_prog_data)
        else $error("serial outputs active outside serial mode");
    a_clock_pin_float: assert property ($past(serial_prog_active) |-> !pin_oe[2])
        else $error("serial clock pin driven");
    a_data_pin_serial: assert property ($past(serial_prog_active) |-> pin_oe[3] == $past(serial_data_oe))
        else $error("serial data enable not followed");
    a_lowvolt_override: assert property ($past(lowvolt_prog_enable_cfg) |-> !pin_oe[1] && !pullup_en[1])
        else $error("entry pin not released");
    a_lowvolt_entry_off: assert property (!$past(lowvolt_prog_enable_cfg) |-> !lowvolt_prog_entry)
        else $error("entry input active while disabled");
    a_pullup_output_off: assert property ((pullup_en & pin_oe) == 4'h0)
        else $error("pull-up on a driven pin");
    a_capcomp_route: assert property ($past(nrst) |-> capcomp_channel_2_here == !$past(capcomp2_pin_select_cfg))
        else $error("channel 2 routing wrong");
    // Main scenarios reached
    c_flag_set: cover property ($rose(port_change_flag));
    c_serial_mode: cover property (serial_prog_active ##1 serial_prog_clock);
    c_latch_rd: cover property (latch_wr_rd);
endmodule : port_b_checker

// *** sim/testbench.sv ***
// Register-level bench for the upper port half
`timescale 1ns/100ps
module testbench;
    import port_b_pkg::*;
    logic clk_sys, nrst, wr_en, rd_en; // Clock, reset, strobes
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data;
    logic [3:0] pin_in, pin_out, pin_oe, pullup_en, ext_level, ext_drive;
    logic lv_cfg, an_cfg, cc_cfg, ser_on, ser_drv, ser_oe; // Config and serial inputs
    logic ser_clk, ser_dat, lv_entry, flag, irq_en, irq_pri, an4, cc_here;
    int n_mismatch = 0;
    int checks = 0;
    logic [7:0] rst_exp [7] = '{8'h00, 8'hff, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    port_b_upper_pins dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_en(pullup_en), .lowvolt_prog_enable_cfg(lv_cfg),
        .analog_at_reset_cfg(an_cfg), .capcomp2_pin_select_cfg(cc_cfg),
        .serial_prog_active(ser_on), .serial_data_drive(ser_drv), .serial_data_oe(ser_oe),
        .serial_prog_clock(ser_clk), .serial_prog_data(ser_dat), .lowvolt_prog_entry(lv_entry),
        .port_change_flag(flag), .port_change_irq_enable(irq_en),
        .port_change_irq_priority(irq_pri), .pin4_analog(an4), .capcomp_channel_2_here(cc_here));
    pin_board board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_level(ext_level), .ext_drive(ext_drive), .pin_in(pin_in));
    // Free-running 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr
    // One-cycle read strobe; data stands only in the next cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp, "rd_data");
    endtask : rd
    // Write then read back to back, no gap between strobes
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp, "rd_data");
    endtask : wr_rd
    // Let edges pass, then sample settled outputs
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle
    // Counts, verdict and stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Cut a hang short; tests need about 150 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        {nrst, wr_en, rd_en, addr, wr_data, lv_cfg, cc_cfg, ser_on, ser_drv, ser_oe} = '0;
        an_cfg = 1'b1;
        ext_level = 4'h0;
        ext_drive = 4'hf;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        idle(2);
        // Reset values and unmapped place
        wr(3'h7, 8'hff);
        for (int i = 0; i < 7; i++) rd(3'(i + 1), rst_exp[i]);
        chk(8'(an4), 8'h01, "pin4_analog");
        chk(8'(cc_here), 8'h01, "capcomp_here");
        wr(ADDR_ANALOG_CFG, 8'hff);
        rd(ADDR_ANALOG_CFG, 8'h3f);
        $display("test reset values done");
        // Outputs from the latch, analog selection ignored
        wr_rd(ADDR_OUT_LATCH, 8'h5a, 8'h5a);
        wr(ADDR_DIRECTION, 8'h0f);
        wr(ADDR_ANALOG_CFG, 8'h00);
        idle(2);
        chk(8'(pin_oe), 8'h0f, "pin_oe");
        chk(8'(pin_out), 8'h05, "pin_out");
        wr(ADDR_ANALOG_CFG, 8'h07);
        wr(ADDR_DIRECTION, 8'hff);
        rd(ADDR_OUT_LATCH, 8'h5a);
        idle(1);
        chk(8'(pin_oe), 8'h00, "pin_oe");
        $display("test outputs done");
        // Pull-ups on inputs only
        ext_drive <= 4'h0;
        wr(ADDR_INT_EDGE, 8'h01);
        idle(8);
        chk(8'(pullup_en), 8'h0f, "pullup_en");
        chk(8'(irq_pri), 8'h01, "irq_priority");
        rd(ADDR_PIN_LEVEL, 8'hf0);
        wr(ADDR_DIRECTION, 8'h0f);
        idle(2);
        chk(8'(pullup_en), 8'h00, "pullup_en");
        wr(ADDR_DIRECTION, 8'hff);
        ext_drive <= 4'hf;
        idle(6);
        $display("test pull-ups done");
        // Synchronised input and change flag
        rd(ADDR_PIN_LEVEL, 8'h00);
        ext_level <= 4'h6;
        rd(ADDR_PIN_LEVEL, 8'h00);
        idle(6);
        rd(ADDR_PIN_LEVEL, 8'h60);
        wr(ADDR_INT_MAIN, 8'h00);
        idle(2);
        chk(8'(flag), 8'h00, "flag");
        ext_level <= 4'h7;
        idle(8);
        chk(8'(flag), 8'h01, "flag");
        wr(ADDR_INT_MAIN, 8'h08);
        idle(2);
        chk(8'(flag), 8'h01, "flag");
        chk(8'(irq_en), 8'h01, "irq_enable");
        rd(ADDR_PIN_LEVEL, 8'h70);
        wr(ADDR_INT_MAIN, 8'h08);
        idle(2);
        chk(8'(flag), 8'h00, "flag");
        $display("test change detect done");
        // Serial programming overrides clock and data pins
        ser_on <= 1'b1;
        ser_oe <= 1'b1;
        ser_drv <= 1'b1;
        ext_level <= 4'h7;
        idle(8);
        chk(8'(ser_clk), 8'h01, "serial_clock");
        chk(8'(ser_dat), 8'h01, "serial_data");
        chk(8'(pin_oe), 8'h08, "pin_oe");
        ext_level <= 4'h3;
        idle(8);
        chk(8'(flag), 8'h00, "flag");
        rd(ADDR_PIN_LEVEL, 8'h30);
        ser_on <= 1'b0;
        $display("test serial mode done");
        // Low-voltage entry ignores direction
        wr(ADDR_DIRECTION, 8'h00);
        lv_cfg <= 1'b1;
        cc_cfg <= 1'b1;
        ext_level <= 4'h2;
        idle(8);
        chk(8'(lv_entry), 8'h01, "lowvolt_entry");
        chk(8'(pin_oe), 8'h0d, "pin_oe");
        chk(8'(cc_here), 8'h00, "capcomp_here");
        $display("test low-voltage entry done");
        // Second reset with digital default
        lv_cfg <= 1'b0;
        an_cfg <= 1'b0;
        nrst <= 1'b0;
        idle(3);
        nrst <= 1'b1;
        idle(3);
        rd(ADDR_ANALOG_CFG, 8'h07);
        chk(8'(an4), 8'h00, "pin4_analog");
        $display("test digital reset done");
        end_of_test();
    end
endmodule : testbench

bind port_b_upper_pins port_b_checker checker_i (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .lowvolt_prog_enable_cfg(lowvolt_prog_enable_cfg),
    .capcomp2_pin_select_cfg(capcomp2_pin_select_cfg), .serial_prog_active(serial_prog_active),
    .serial_data_oe(serial_data_oe), .serial_prog_clock(serial_prog_clock),
    .serial_prog_data(serial_prog_data), .lowvolt_prog_entry(lowvolt_prog_entry),
    .port_change_flag(port_change_flag), .capcomp_channel_2_here(capcomp_channel_2_here));
